//--- dv/fpurs_core_model.sv
// Integer core model issuing system load/store accesses
`timescale 1ns/1ps
`default_nettype none
module fpurs_core_model
(
    // Clock
    input wire logic sys_clk,
    // System store requests
    output logic sysWrValid,
    output fpurs_pkg::fpurs_sysreg_e sysWrSel,
    output logic [31:0] sysWrData,
    // System load requests and answer
    output logic sysRdValid,
    output fpurs_pkg::fpurs_sysreg_e sysRdSel,
    input wire logic sysRdDone,
    input wire logic [31:0] sysRdData
);
    initial
    begin
        sysWrValid = 1'b0;
        sysWrSel = fpurs_pkg::SEL_STATUS;
        sysWrData = 32'h0000_0000;
        sysRdValid = 1'b0;
        sysRdSel = fpurs_pkg::SEL_STATUS;
    end

    // Core words reach the FPU only through these accesses
    task sys_write(input fpurs_pkg::fpurs_sysreg_e sel,
                   input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        sysWrValid = 1'b1;
        sysWrSel = sel;
        sysWrData = d;
        @(posedge sys_clk);
        #1;
        sysWrValid = 1'b0;
        // Released data shows junk so a stale word cannot pass
        sysWrData = ~d;
    endtask : sys_write

    task sys_read(input fpurs_pkg::fpurs_sysreg_e sel, output logic done,
                  output logic [31:0] d);
        @(posedge sys_clk);
        #1;
        sysRdValid = 1'b1;
        sysRdSel = sel;
        @(posedge sys_clk);
        #1;
        sysRdValid = 1'b0;
        done = sysRdDone;
        d = sysRdData;
    endtask : sys_read

    // Store then load in back-to-back cycles
    task sys_wr_rd(input fpurs_pkg::fpurs_sysreg_e sel, input logic [31:0] d,
                   output logic done, output logic [31:0] q);
        @(posedge sys_clk);
        #1;
        sysWrValid = 1'b1;
        sysWrSel = sel;
        sysWrData = d;
        @(posedge sys_clk);
        #1;
        sysWrValid = 1'b0;
        sysWrData = ~d;
        sysRdValid = 1'b1;
        sysRdSel = sel;
        @(posedge sys_clk);
        #1;
        sysRdValid = 1'b0;
        done = sysRdDone;
        q = sysRdData;
    endtask : sys_wr_rd
endmodule : fpurs_core_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the status and rounding block
`timescale 1ns/1ps
`default_nettype none
`define CMP(what, expv, gotv) \
    begin \
        checksDone++; \
        if ((gotv) !== (expv)) \
        begin \
            errTotal++; \
            $display("unexpected %s expected %h seen %h", what, expv, gotv); \
        end \
    end
module testbench;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic sysWrValid, sysRdValid, sysRdDone, fpuXferWr = 1'b0;
    fpurs_pkg::fpurs_sysreg_e sysWrSel, sysRdSel;
    logic [31:0] sysWrData, sysRdData, xferToFpu;
    logic [31:0] fpuXferData = 32'h0000_0000;
    fpurs_pkg::fpurs_op_s opIn = '0;
    fpurs_pkg::fpurs_res_s resOut;
    int errTotal = 0;
    int checksDone = 0;

    always #4 sys_clk = ~sys_clk;

    fpurs_status_round fpurs_status_round_i (.sys_clk(sys_clk),
        .resetn(resetn), .sysWrValid(sysWrValid), .sysWrSel(sysWrSel),
        .sysWrData(sysWrData), .sysRdValid(sysRdValid), .sysRdSel(sysRdSel),
        .sysRdDone(sysRdDone), .sysRdData(sysRdData), .fpuXferWr(fpuXferWr),
        .fpuXferData(fpuXferData), .xferToFpu(xferToFpu), .op(opIn),
        .res(resOut));
    fpurs_core_model fpurs_core_model_i (.sys_clk(sys_clk),
        .sysWrValid(sysWrValid), .sysWrSel(sysWrSel), .sysWrData(sysWrData),
        .sysRdValid(sysRdValid), .sysRdSel(sysRdSel), .sysRdDone(sysRdDone),
        .sysRdData(sysRdData));

    function automatic logic [31:0] stw(logic [5:0] c, logic [4:0] e,
                                        logic [4:0] f, logic [1:0] r);
        return {14'h0000, c, e, f, r};
    endfunction : stw

    task wr_stat(input logic [31:0] d);
        fpurs_core_model_i.sys_write(fpurs_pkg::SEL_STATUS, d);
    endtask : wr_stat

    task rd_chk(input fpurs_pkg::fpurs_sysreg_e sel, input logic [31:0] e);
        logic done;
        logic [31:0] d;
        fpurs_core_model_i.sys_read(sel, done, d);
        `CMP("read done", 1'b1, done)
        `CMP("read data", e, d)
    endtask : rd_chk

    // One op; result checked in the cycle its valid pulse stands
    // Source bits: invalid, divide-by-zero, underflow, error
    task do_op(input logic dbl, input logic sgn, input logic [11:0] e,
               input logic [55:0] m, input logic [3:0] src, input logic wr,
               input logic [63:0] d);
        fpurs_pkg::fpurs_op_s o;
        o = '0;
        o.valid = 1'b1;
        o.dbl = dbl;
        o.sign = sgn;
        o.exp = e;
        o.mant = m;
        o.invalid = src[3];
        o.divZero = src[2];
        o.underflow = src[1];
        o.error = src[0];
        @(posedge sys_clk);
        #1;
        opIn = o;
        @(posedge sys_clk);
        #1;
        opIn.valid = 1'b0;
        `CMP("res valid", 1'b1, resOut.valid)
        `CMP("res write", wr, resOut.write)
        `CMP("res taken", ~wr, resOut.taken)
        `CMP("res data", d, resOut.data)
    endtask : do_op

    task t_xfer;
        logic done;
        logic [31:0] q;
        fpurs_core_model_i.sys_write(fpurs_pkg::SEL_XFER, 32'hA5A5_0F0F);
        `CMP("to fpu", 32'hA5A5_0F0F, xferToFpu)
        @(posedge sys_clk);
        #1;
        fpuXferWr = 1'b1;
        fpuXferData = 32'h1234_5678;
        @(posedge sys_clk);
        #1;
        fpuXferWr = 1'b0;
        fpuXferData = 32'hEDCB_A987;
        rd_chk(fpurs_pkg::SEL_XFER, 32'h1234_5678);
        fpurs_core_model_i.sys_wr_rd(fpurs_pkg::SEL_XFER, 32'h5A5A_F0F0,
                                     done, q);
        `CMP("loop done", 1'b1, done)
        `CMP("loop data", 32'h5A5A_F0F0, q)
    endtask : t_xfer

    task t_round;
        wr_stat(stw(6'h00, 5'h00, 5'h00, fpurs_pkg::RM_NEAREST));
        do_op(0, 0, 12'h080, 56'h80_0000_8000_0000, 0, 1,
              64'h0000_0000_4000_0000);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_1004);
        do_op(0, 0, 12'h080, 56'h80_0001_8000_0000, 0, 1,
              64'h0000_0000_4000_0002);
        do_op(1, 0, 12'h400, 56'h80_0000_0000_000C, 0, 1,
              64'h4000_0000_0000_0002);
        wr_stat(stw(6'h00, 5'h00, 5'h01, fpurs_pkg::RM_ZERO));
        do_op(0, 0, 12'h080, 56'h80_0001_8000_0000, 0, 1,
              64'h0000_0000_4000_0001);
        do_op(0, 1, 12'h100, 56'hFF_FFFF_8000_0000, 0, 1,
              64'h0000_0000_FF7F_FFFF);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_5015);
        wr_stat(stw(6'h00, 5'h00, 5'h05, 2'h2));
        do_op(0, 0, 12'h080, 56'h80_0001_8000_0000, 0, 1,
              64'h0000_0000_4000_0001);
        wr_stat(stw(6'h00, 5'h00, 5'h05, fpurs_pkg::RM_NEAREST));
        do_op(0, 0, 12'h0FE, 56'hFF_FFFF_8000_0000, 0, 1,
              64'h0000_0000_7F80_0000);
        do_op(0, 1, 12'h100, 56'h80_0000_0000_0000, 0, 1,
              64'h0000_0000_FF80_0000);
    endtask : t_round

    task t_status;
        do_op(0, 0, 12'h07F, 56'h80_0000_0000_0000, 0, 1,
              64'h0000_0000_3F80_0000);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_0014);
        wr_stat(stw(6'h00, 5'h01, 5'h00, fpurs_pkg::RM_NEAREST));
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_0080);
        do_op(0, 0, 12'h080, 56'h80_0000_8000_0000, 0, 0,
              64'h0000_0000_3F80_0000);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_1084);
        wr_stat(stw(6'h00, 5'h00, 5'h00, fpurs_pkg::RM_NEAREST));
        do_op(0, 0, 12'h07F, 56'h80_0000_0000_0000, 1, 0,
              64'h0000_0000_3F80_0000);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0002_0000);
        do_op(0, 1, 12'h07F, 56'h80_0000_0000_0000, 4'h4, 1,
              64'h0000_0000_FF80_0000);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_8020);
        do_op(0, 1, 12'h07F, 56'h80_0000_0000_0000, 4'hC, 1,
              64'h0000_0000_7FC0_0000);
        do_op(0, 0, 12'h001, 56'h80_0000_0000_0000, 4'h2, 1,
              64'h0000_0000_0080_0000);
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_306C);
    endtask : t_status

    task test_done;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        #50000;
        errTotal++;
        test_done();
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        `CMP("xfer reset", 32'h0000_0000, xferToFpu)
        rd_chk(fpurs_pkg::SEL_STATUS, 32'h0000_0001);
        t_xfer();
        t_round();
        t_status();
        test_done();
    end
endmodule : testbench
`default_nettype wire

//--- pkg/fpurs_pkg.sv
// Constants and carriers for the FPU rounding and exception status block
package fpurs_pkg;
    // Status/control word field layout
    localparam int RM_LSB = 0;
    localparam int RM_W = 2;
    localparam int FLAG_LSB = 2;
    localparam int FLAG_W = 5;
    localparam int EN_LSB = 7;
    localparam int EN_W = 5;
    localparam int CAUSE_LSB = 12;
    localparam int CAUSE_W = 6;
    // Source index inside each field (enable and flag lack the error bit)
    localparam int SRC_INEXACT = 0;
    localparam int SRC_UNDER = 1;
    localparam int SRC_OVER = 2;
    localparam int SRC_DIVZ = 3;
    localparam int SRC_INVALID = 4;
    localparam int SRC_ERROR = 5;
    // Rounding selector codes
    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_RESET = RM_ZERO;
    localparam logic [4:0] EN_RESET = 5'h00;
    localparam logic [4:0] FLAG_RESET = 5'h00;
    localparam logic [5:0] CAUSE_RESET = 6'h00;
    localparam logic [31:0] XFER_RESET = 32'h0000_0000;
    // Formats: exponent all-ones codes and significand positions
    localparam logic [12:0] SGL_EXP_MAX = 13'h00FF;
    localparam logic [12:0] DBL_EXP_MAX = 13'h07FF;
    localparam int MANT_W = 56;
    localparam int SGL_LSB = 32;
    localparam int DBL_LSB = 3;

    typedef enum logic {SEL_STATUS, SEL_XFER} fpurs_sysreg_e;

    // Unrounded operation: mant[55] is the leading one
    typedef struct packed {
        logic valid;
        logic dbl;
        logic sign;
        logic [11:0] exp;
        logic [MANT_W-1:0] mant;
        logic error;
        logic invalid;
        logic divZero;
        logic underflow;
    } fpurs_op_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic taken;
        logic [63:0] data;
    } fpurs_res_s;

    typedef struct packed {
        logic [1:0] rm;
        logic [4:0] enable;
        logic [4:0] flag;
        logic [5:0] cause;
        logic [31:0] xfer;
        logic [31:0] rdData;
        logic rdValid;
        fpurs_res_s res;
    } fpurs_state_s;
endpackage : fpurs_pkg

//--- src/fpurs_status_round.sv
// FPU status/control, transfer register and final rounding stage
`timescale 1ns/1ps
`default_nettype none
module fpurs_status_round
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Core system load/store access
    input wire logic sysWrValid,
    input wire fpurs_pkg::fpurs_sysreg_e sysWrSel,
    input wire logic [31:0] sysWrData,
    input wire logic sysRdValid,
    input wire fpurs_pkg::fpurs_sysreg_e sysRdSel,
    output logic sysRdDone,
    output logic [31:0] sysRdData,
    // FPU side of the transfer register
    input wire logic fpuXferWr,
    input wire logic [31:0] fpuXferData,
    output logic [31:0] xferToFpu,
    // Unrounded operation in, final result out
    input wire fpurs_pkg::fpurs_op_s op,
    output fpurs_pkg::fpurs_res_s res
);
    fpurs_pkg::fpurs_state_s state_reg;
    fpurs_pkg::fpurs_state_s state_next;

    logic [52:0] keep;
    logic lsb;
    logic rnd;
    logic stk;
    logic roundUp;
    logic [53:0] rounded;
    logic carry;
    logic [12:0] expR;
    logic [12:0] expMax;
    logic ovf;
    logic nearest;
    logic [5:0] newCause;
    logic taken;
    logic [63:0] result;
    logic [31:0] statusWord;

    // Reserved codes 10/11 fall back to truncation
    assign nearest = state_reg.rm == fpurs_pkg::RM_NEAREST;
    assign keep = op.dbl ? op.mant[55:fpurs_pkg::DBL_LSB]
                         : {29'h0, op.mant[55:fpurs_pkg::SGL_LSB]};
    assign lsb = keep[0];
    assign rnd = op.dbl ? op.mant[fpurs_pkg::DBL_LSB-1]
                        : op.mant[fpurs_pkg::SGL_LSB-1];
    assign stk = op.dbl ? |op.mant[fpurs_pkg::DBL_LSB-2:0]
                        : |op.mant[fpurs_pkg::SGL_LSB-2:0];
    // Zero mode never increments: round bit and sticky bits drop
    assign roundUp = nearest & rnd & (stk | lsb);
    assign rounded = {1'b0, keep} + {53'h0, roundUp};
    assign carry = op.dbl ? rounded[53] : rounded[24];
    assign expR = {1'b0, op.exp} + {12'h0, carry};
    assign expMax = op.dbl ? fpurs_pkg::DBL_EXP_MAX : fpurs_pkg::SGL_EXP_MAX;
    // Checked after rounding, so 2^Emax(2-2^-P) rounds up into overflow
    assign ovf = expR >= expMax;

    // Index order matches enable and flag fields
    always_comb
    begin
        newCause = 6'h00;
        newCause[fpurs_pkg::SRC_ERROR] = op.error;
        newCause[fpurs_pkg::SRC_INVALID] = op.invalid;
        newCause[fpurs_pkg::SRC_DIVZ] = op.divZero & ~op.invalid;
        if (!op.invalid && !op.divZero)
        begin
            newCause[fpurs_pkg::SRC_OVER] = ovf;
            newCause[fpurs_pkg::SRC_UNDER] = op.underflow;
            newCause[fpurs_pkg::SRC_INEXACT] = rnd | stk | ovf | op.underflow;
        end
    end

    // Error cannot be masked; others gated by enables
    assign taken = newCause[fpurs_pkg::SRC_ERROR]
                   | (|(newCause[4:0] & state_reg.enable));

    always_comb
    begin
        result = 64'h0;
        if (op.invalid)
        begin
            result = op.dbl ? {1'b0, 11'h7FF, 1'b1, 51'h0}
                            : {32'h0, 1'b0, 8'hFF, 1'b1, 22'h0};
        end
        else if (op.divZero || (ovf && nearest))
        begin
            result = op.dbl ? {op.sign, 11'h7FF, 52'h0}
                            : {32'h0, op.sign, 8'hFF, 23'h0};
        end
        else if (ovf)
        begin
            result = op.dbl ? {op.sign, 11'h7FE, {52{1'b1}}}
                            : {32'h0, op.sign, 8'hFE, {23{1'b1}}};
        end
        else if (op.dbl)
        begin
            result = {op.sign, expR[10:0], rounded[51:0]};
        end
        else
        begin
            result = {32'h0, op.sign, expR[7:0], rounded[22:0]};
        end
    end

    assign statusWord = {14'h0, state_reg.cause, state_reg.enable,
                         state_reg.flag, state_reg.rm};

    always_comb
    begin
        state_next = state_reg;
        state_next.rdValid = 1'b0;
        state_next.res.valid = 1'b0;
        state_next.res.write = 1'b0;
        state_next.res.taken = 1'b0;
        if (sysWrValid && sysWrSel == fpurs_pkg::SEL_STATUS)
        begin
            state_next.rm = sysWrData[fpurs_pkg::RM_LSB +: fpurs_pkg::RM_W];
            state_next.enable = sysWrData[fpurs_pkg::EN_LSB +: fpurs_pkg::EN_W];
            state_next.flag = sysWrData[fpurs_pkg::FLAG_LSB +: fpurs_pkg::FLAG_W];
            state_next.cause =
                sysWrData[fpurs_pkg::CAUSE_LSB +: fpurs_pkg::CAUSE_W];
        end
        // Core write wins over an FPU write in the same cycle
        if (sysWrValid && sysWrSel == fpurs_pkg::SEL_XFER)
        begin
            state_next.xfer = sysWrData;
        end
        else if (fpuXferWr)
        begin
            state_next.xfer = fpuXferData;
        end
        if (op.valid)
        begin
            // Operation overrides a same-cycle cause write; a flag set
            // also wins over a same-cycle software clear
            state_next.cause = newCause;
            state_next.flag = state_next.flag | newCause[4:0];
            state_next.res.valid = 1'b1;
            state_next.res.taken = taken;
            state_next.res.write = ~taken;
            if (!taken)
            begin
                state_next.res.data = result;
            end
        end
        if (sysRdValid)
        begin
            state_next.rdValid = 1'b1;
            state_next.rdData = sysRdSel == fpurs_pkg::SEL_STATUS
                                ? statusWord : state_reg.xfer;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '0;
            state_reg.rm <= fpurs_pkg::RM_RESET;
            state_reg.enable <= fpurs_pkg::EN_RESET;
            state_reg.flag <= fpurs_pkg::FLAG_RESET;
            state_reg.cause <= fpurs_pkg::CAUSE_RESET;
            state_reg.xfer <= fpurs_pkg::XFER_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sysRdDone = state_reg.rdValid;
    assign sysRdData = state_reg.rdData;
    assign xferToFpu = state_reg.xfer;
    assign res = state_reg.res;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence xferWrite;
        sysWrValid && sysWrSel == fpurs_pkg::SEL_XFER;
    endsequence
    sequence xferRead;
        sysRdValid && sysRdSel == fpurs_pkg::SEL_XFER && !sysWrValid
            && !fpuXferWr;
    endsequence
    sequence sglPlain;
        op.valid && !op.dbl && !op.invalid && !op.divZero && !op.error
            && state_reg.enable == 5'h00;
    endsequence

    chk_cause_fresh: assert property (op.valid |=>
        state_reg.cause == $past(newCause))
        else $error("cause field not rebuilt by operation");
    chk_flag_sticky: assert property (
        !(sysWrValid && sysWrSel == fpurs_pkg::SEL_STATUS)
        |=> (state_reg.flag & $past(state_reg.flag)) == $past(state_reg.flag))
        else $error("flag bit dropped without software write");
    chk_flag_divzero: assert property (
        op.valid && op.divZero && !op.invalid |=> state_reg.flag[3]
        && state_reg.cause[3])
        else $error("divide-by-zero not recorded");
    chk_mode_write: assert property (
        sysWrValid && sysWrSel == fpurs_pkg::SEL_STATUS
        |=> state_reg.rm == $past(sysWrData[1:0]))
        else $error("rounding selector write lost");
    chk_xfer_loop: assert property (
        xferWrite ##1 xferRead |=> sysRdDone
        && sysRdData == $past(sysWrData, 2))
        else $error("transfer register did not return written word");
    chk_rn_inf: assert property (
        sglPlain and nearest && op.exp >= 12'h0FF
        |=> res.data[30:0] == 31'h7F80_0000)
        else $error("nearest overflow not infinity");
    chk_rz_max: assert property (
        sglPlain and !nearest && op.exp >= 12'h0FF
        |=> res.data[30:0] == 31'h7F7F_FFFF && res.data[31] == $past(op.sign))
        else $error("zero-mode overflow not largest finite");
    chk_rz_trunc: assert property (
        sglPlain and !nearest && op.exp < 12'h0FE
        |=> res.data[22:0] == $past(op.mant[54:32]))
        else $error("zero mode did not truncate");
    chk_tie_even: assert property (
        sglPlain and nearest && op.exp < 12'h0FE && op.mant[31]
        && op.mant[30:0] == 31'h0 && !op.mant[32]
        |=> res.data[22:0] == $past(op.mant[54:32]))
        else $error("tie not rounded to even");
    chk_dest_hold: assert property (
        op.valid && op.error |=> res.valid && res.taken && !res.write
        && res.data == $past(res.data))
        else $error("error exception wrote destination");
endmodule : fpurs_status_round
`default_nettype wire
